// File: core/usbie_defines.svh
// Offsets, field positions and reset values of the interrupt enable block
`ifndef USBIE_DEFINES_SVH
`define USBIE_DEFINES_SVH

// Register byte offsets
`define USBIE_MODE_OFS 8'h0C
`define USBIE_CFG_OFS 8'h10
`define USBIE_MASK_OFS 8'h14
`define USBIE_STAT_OFS 8'h18

// Mask register values and implemented bits
`define USBIE_MASK_RST 32'h0000_0000
`define USBIE_MASK_BRST 32'h0000_0001
`define USBIE_MASK_VALID 32'h03FF_FDFF

// Field positions
`define USBIE_GLB_BIT 0
`define USBIE_CTRL_POL_LSB 0
`define USBIE_DIN_POL_LSB 2
`define USBIE_DOUT_POL_LSB 4
`define USBIE_CFG_RST 6'h00
`define USBIE_SETUP_BIT 8
`define USBIE_COUT_BIT 10
`define USBIE_CIN_BIT 11
`define USBIE_EP_BASE 12
`define USBIE_BRST_BIT 0

// Bus answers
`define USBIE_RESP_OKAY 2'h0
`define USBIE_RESP_SLVERR 2'h2

`endif

// File: core/usbie_pkg.sv
// Types shared by the interrupt enable block
`default_nettype none
package usbie_pkg;
	// Which handshakes raise an endpoint event
	typedef enum logic [1:0] {
		USBIE_POL_ACK_NAK = 2'h0,
		USBIE_POL_ACK_ONLY = 2'h1,
		USBIE_POL_ACK_FIRST_NAK = 2'h2,
		USBIE_POL_RSVD = 2'h3
	} usbie_policy_t;
endpackage
`default_nettype wire

// File: core/usbie_hs_filter.sv
// Handshake filter: turns ACK/NAK pulses into an event per policy
`default_nettype none
module usbie_hs_filter (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Policy and handshakes
	input wire usbie_pkg::usbie_policy_t i_policy,
	input wire logic i_ack,
	input wire logic i_nak,
	// Filtered event
	output logic o_event
);
	logic nak_armed;
	wire nak_pass;

	// Reserved policy code behaves as ACK only
	assign nak_pass = (i_policy == usbie_pkg::USBIE_POL_ACK_NAK) |
		((i_policy == usbie_pkg::USBIE_POL_ACK_FIRST_NAK) & nak_armed);
	assign o_event = i_ack | (i_nak & nak_pass);

	// An ACK rearms; under the first-NAK policy only the first NAK after it passes
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			nak_armed <= 1'h1;
		end else if (i_ack) begin
			nak_armed <= 1'h1;
		end else if (i_nak) begin
			nak_armed <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// File: core/usbie_top.sv
// Interrupt enable mask, sticky status and AXI4-Lite register slave
// Functional notes
// [R1] Separate enable per endpoint direction
// [R2] Global enable clear suppresses interrupt output
// [R3] ACK or NAK handshake raises endpoint event
// [R4] Three two-bit policy fields select handshakes
// [R5] Data IN events follow IN policy
// [R6] Data OUT events follow OUT policy
// [R7] Control endpoint events follow control policy
// [R8] Bus reset clears mask, sets reset bit
// [R9] Mask is 32-bit RW, resets zero
// [R10] Endpoints 1-7: RX even, TX odd, 12-25
// [R11] Bits 11 IN, 10 OUT, 8 setup
// [R12] Bit 7 bus power, bit 6 DMA
// [R13] Bits 5 speed, 4 resume, 3 suspend
// [R14] Bits 2 pseudo frame, 1 frame, 0 reset
// [R15] Reserved bits ignore writes, read zero
// [R16] Output high while enabled source pending
`include "usbie_defines.svh"
`default_nettype none
module usbie_top (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// AXI4-Lite write address and data
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// AXI4-Lite write response
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// Handshake pulses from the serial interface engine, index 0 = control
	input wire logic [7:0] i_rx_ack,
	input wire logic [7:0] i_rx_nak,
	input wire logic [7:0] i_tx_ack,
	input wire logic [7:0] i_tx_nak,
	input wire logic i_setup_rcvd,
	// Bus event pulses in mask layout, bit 0 = bus reset
	input wire logic [7:0] i_bus_events,
	// Interrupt request
	output logic o_irq
);
	logic glb_en;
	logic [5:0] cfg;
	logic [31:0] enable;
	logic [31:0] status;
	logic aw_full;
	logic [7:0] aw_addr;
	logic w_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire [31:0] ev;
	wire [7:0] ev_rx;
	wire [7:0] ev_tx;
	wire ev_setup;

	// Policy fields of the configuration register
	wire usbie_pkg::usbie_policy_t ctrl_pol;
	wire usbie_pkg::usbie_policy_t din_pol;
	wire usbie_pkg::usbie_policy_t dout_pol;
	assign ctrl_pol = usbie_pkg::usbie_policy_t'(
		cfg[`USBIE_CTRL_POL_LSB +: 2]); // [R4]
	assign din_pol = usbie_pkg::usbie_policy_t'(cfg[`USBIE_DIN_POL_LSB +: 2]);
	assign dout_pol = usbie_pkg::usbie_policy_t'(
		cfg[`USBIE_DOUT_POL_LSB +: 2]);

	// One filter per endpoint direction; endpoint 0 uses the control field
	generate
		for (genvar i = 0; i < 8; i++) begin : g_ep
			usbie_hs_filter u_rx (
				.i_core_clk(i_core_clk),
				.i_sys_rst(i_sys_rst),
				.i_policy((i == 0) ? ctrl_pol : dout_pol), // [R6] [R7]
				.i_ack(i_rx_ack[i]),
				.i_nak(i_rx_nak[i]),
				.o_event(ev_rx[i])
			);
			usbie_hs_filter u_tx (
				.i_core_clk(i_core_clk),
				.i_sys_rst(i_sys_rst),
				.i_policy((i == 0) ? ctrl_pol : din_pol), // [R5] [R7]
				.i_ack(i_tx_ack[i]),
				.i_nak(i_tx_nak[i]),
				.o_event(ev_tx[i])
			);
			if (i > 0) begin : g_data
				assign ev[`USBIE_EP_BASE + 2 * (i - 1)] = ev_rx[i]; // [R10]
				assign ev[`USBIE_EP_BASE + 2 * (i - 1) + 1] = ev_tx[i];
			end
		end
	endgenerate

	// SETUP is always acknowledged, still routed through the control field
	usbie_hs_filter u_setup (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_policy(ctrl_pol), // [R7]
		.i_ack(i_setup_rcvd),
		.i_nak(1'h0),
		.o_event(ev_setup)
	);

	// Event vector in mask layout; reserved positions never set
	assign ev[31:26] = 6'h00; // [R15]
	assign ev[`USBIE_CIN_BIT] = ev_tx[0]; // [R11]
	assign ev[`USBIE_COUT_BIT] = ev_rx[0];
	assign ev[9] = 1'h0;
	assign ev[`USBIE_SETUP_BIT] = ev_setup;
	assign ev[7:0] = i_bus_events; // [R12] [R13] [R14]

	// Write path: address and data may arrive in either order
	wire aw_take = i_awvalid & o_awready;
	wire w_take = i_wvalid & o_wready;
	wire aw_have = aw_full | aw_take;
	wire w_have = w_full | w_take;
	wire do_write = aw_have & w_have & ~o_bvalid;
	wire [7:0] wr_addr = aw_full ? aw_addr : i_awaddr;
	wire [31:0] wr_data = w_full ? w_data : i_wdata;
	wire [3:0] wr_strb = w_full ? w_strb : i_wstrb;
	wire [7:0] wr_ofs = {wr_addr[7:2], 2'h0};
	wire [31:0] byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
		{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire wr_mode = do_write & (wr_ofs == `USBIE_MODE_OFS);
	wire wr_cfg = do_write & (wr_ofs == `USBIE_CFG_OFS);
	wire wr_mask = do_write & (wr_ofs == `USBIE_MASK_OFS);
	wire wr_stat = do_write & (wr_ofs == `USBIE_STAT_OFS);
	wire wr_hit = wr_mode | wr_cfg | wr_mask | wr_stat;
	wire next_aw_full = aw_have & ~do_write;
	wire next_w_full = w_have & ~do_write;
	wire next_bvalid = do_write | (o_bvalid & ~i_bready);

	// Register next values
	wire bus_rst = i_bus_events[`USBIE_BRST_BIT];
	wire [31:0] merged_mask = (enable & ~byte_mask) | (wr_data & byte_mask);
	wire [31:0] next_enable = bus_rst ? `USBIE_MASK_BRST : // [R8]
		wr_mask ? (merged_mask & `USBIE_MASK_VALID) : enable; // [R9] [R15]
	wire [31:0] stat_clr = wr_stat ? (wr_data & byte_mask) : 32'h0000_0000;
	// New event beats a simultaneous write-one-to-clear
	wire [31:0] next_status = ((status & ~stat_clr) | ev) & `USBIE_MASK_VALID;
	wire next_glb_en = (wr_mode & wr_strb[0]) ?
		wr_data[`USBIE_GLB_BIT] : glb_en;
	wire [5:0] next_cfg = (wr_cfg & wr_strb[0]) ? wr_data[5:0] : cfg;
	wire pending = |(status & enable); // [R1] [R16]
	wire next_irq = glb_en & pending; // [R2]

	// Read path: one read outstanding, data latched at address accept
	wire ar_take = i_arvalid & o_arready;
	wire [7:0] rd_ofs = {i_araddr[7:2], 2'h0};
	wire rd_mode = (rd_ofs == `USBIE_MODE_OFS);
	wire rd_cfg = (rd_ofs == `USBIE_CFG_OFS);
	wire rd_mask = (rd_ofs == `USBIE_MASK_OFS);
	wire rd_stat = (rd_ofs == `USBIE_STAT_OFS);
	wire rd_hit = rd_mode | rd_cfg | rd_mask | rd_stat;
	wire [31:0] rd_val = rd_mode ? {31'h0000_0000, glb_en} :
		rd_cfg ? {26'h000_0000, cfg} :
		rd_mask ? enable :
		rd_stat ? status : 32'h0000_0000;
	wire next_rvalid = ar_take | (o_rvalid & ~i_rready);

	// Control and mask registers
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			glb_en <= 1'h0;
			cfg <= `USBIE_CFG_RST;
			enable <= `USBIE_MASK_RST; // [R9]
			status <= 32'h0000_0000;
			o_irq <= 1'h0;
		end else begin
			glb_en <= next_glb_en;
			cfg <= next_cfg;
			enable <= next_enable;
			status <= next_status; // [R3]
			o_irq <= next_irq; // [R16]
		end
	end

	// Write channel holding registers
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			aw_full <= 1'h0;
			w_full <= 1'h0;
			o_awready <= 1'h0;
			o_wready <= 1'h0;
			o_bvalid <= 1'h0;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			o_awready <= ~next_aw_full & ~next_bvalid;
			o_wready <= ~next_w_full & ~next_bvalid;
			o_bvalid <= next_bvalid;
		end
	end

	// Payload captures, no reset needed beyond a defined answer
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			o_bresp <= `USBIE_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_addr <= i_awaddr;
			end
			if (w_take) begin
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (do_write) begin
				o_bresp <= wr_hit ? `USBIE_RESP_OKAY : `USBIE_RESP_SLVERR;
			end
		end
	end

	// Read channel
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_arready <= 1'h0;
			o_rvalid <= 1'h0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `USBIE_RESP_OKAY;
		end else begin
			o_arready <= ~next_rvalid;
			o_rvalid <= next_rvalid;
			if (ar_take) begin
				o_rdata <= rd_val; // [R15]
				o_rresp <= rd_hit ? `USBIE_RESP_OKAY : `USBIE_RESP_SLVERR;
			end
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_global_gate: assert property ( // [R2]
		!glb_en |=> !o_irq
	) else $error("irq high while global enable clear");

	a_irq_cause: assert property ( // [R16]
		(glb_en && (status & enable) != 32'h0000_0000) |=> o_irq
	) else $error("enabled pending source gave no irq");

	a_busrst_force: assert property ( // [R8]
		bus_rst |=> (enable == `USBIE_MASK_BRST) && status[0]
	) else $error("bus reset did not force mask");

	a_rsvd_zero: assert property ( // [R15]
		((enable | status) & ~`USBIE_MASK_VALID) == 32'h0000_0000
	) else $error("reserved bit set");

	a_mask_write: assert property ( // [R9]
		(wr_mask && wr_strb == 4'hF && !bus_rst) |=>
			enable == ($past(wr_data) & `USBIE_MASK_VALID)
	) else $error("mask write not stored");

	a_ack_event: assert property ( // [R3]
		i_rx_ack[1] |=> status[`USBIE_EP_BASE]
	) else $error("ack on receive endpoint 1 not latched");

	a_din_policy: assert property ( // [R5]
		(din_pol == usbie_pkg::USBIE_POL_ACK_ONLY && i_tx_nak[1] &&
			!i_tx_ack[1]) |-> !ev[`USBIE_EP_BASE + 1]
	) else $error("nak passed under ack only IN policy");

	a_dout_policy: assert property ( // [R6]
		(dout_pol == usbie_pkg::USBIE_POL_ACK_ONLY && i_rx_nak[1] &&
			!i_rx_ack[1]) |-> !ev[`USBIE_EP_BASE]
	) else $error("nak passed under ack only OUT policy");

	a_ctrl_policy: assert property ( // [R7]
		(ctrl_pol == usbie_pkg::USBIE_POL_ACK_NAK && i_tx_nak[0])
			|=> status[`USBIE_CIN_BIT]
	) else $error("control IN nak not latched");

	a_first_nak: assert property ( // [R4]
		(dout_pol == usbie_pkg::USBIE_POL_ACK_FIRST_NAK && i_rx_nak[2] &&
			!i_rx_ack[2]) ##1 (i_rx_nak[2] && !i_rx_ack[2] &&
			$stable(dout_pol)) |-> !ev[`USBIE_EP_BASE + 2]
	) else $error("second nak passed under first nak policy");

	a_bus_bits: assert property ( // [R12] [R13] [R14]
		i_bus_events[7] |=> status[7]
	) else $error("bus power event not latched");

	a_setup_bit: assert property ( // [R11]
		i_setup_rcvd |=> status[`USBIE_SETUP_BIT]
	) else $error("setup event not latched");

	a_bresp_hold: assert property (
		(o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp)
	) else $error("write response dropped");
endmodule
`default_nettype wire

// File: tb/usbie_sie_model.sv
// Model of the serial engine: handshake and bus event pulses
`default_nettype none
module usbie_sie_model (
	// Clock
	input wire logic i_core_clk,
	// Pulses toward the block, one cycle each
	output var logic [7:0] o_rx_ack,
	output var logic [7:0] o_rx_nak,
	output var logic [7:0] o_tx_ack,
	output var logic [7:0] o_tx_nak,
	output var logic o_setup_rcvd,
	output var logic [7:0] o_bus_events
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet lines until a pulse is asked for
	initial begin
		o_rx_ack = 8'h00;
		o_rx_nak = 8'h00;
		o_tx_ack = 8'h00;
		o_tx_nak = 8'h00;
		o_setup_rcvd = 1'h0;
		o_bus_events = 8'h00;
	end

	// One pulse for the source behind mask bit b
	task automatic fire(input int b, input bit nak);
		int i;
		bit rx;
		i = (b < 12) ? 0 : (b - 12) / 2 + 1;
		rx = (b < 12) ? (b == 10) : (b % 2 == 0);
		@(posedge i_core_clk);
		if (b < 8) o_bus_events[b] <= 1'h1;
		else if (b == 8) o_setup_rcvd <= 1'h1;
		else if (rx && nak) o_rx_nak[i] <= 1'h1;
		else if (rx) o_rx_ack[i] <= 1'h1;
		else if (nak) o_tx_nak[i] <= 1'h1;
		else o_tx_ack[i] <= 1'h1;
		@(posedge i_core_clk);
		o_rx_ack <= 8'h00;
		o_rx_nak <= 8'h00;
		o_tx_ack <= 8'h00;
		o_tx_nak <= 8'h00;
		o_setup_rcvd <= 1'h0;
		o_bus_events <= 8'h00;
	endtask

	// Two NAKs in a row on the receive side of mask bit b (12 and up)
	task automatic nak_pair(input int b);
		int i;
		i = (b - 12) / 2 + 1;
		@(posedge i_core_clk);
		o_rx_nak[i] <= 1'h1;
		repeat (2) @(posedge i_core_clk);
		o_rx_nak <= 8'h00;
	endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the interrupt enable block
`include "usbie_defines.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
	logic i_arvalid = 1'h0, i_rready = 1'h0;
	logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'h0;
	wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	wire logic [1:0] o_bresp, o_rresp;
	wire logic [31:0] o_rdata;
	wire logic [7:0] i_rx_ack, i_rx_nak, i_tx_ack, i_tx_nak, i_bus_events;
	wire logic i_setup_rcvd;
	int error_cnt = 0, check_count = 0, seed, b;
	logic [31:0] rd, d;
	logic [1:0] rs;

	// 100 MHz clock
	always #5 i_core_clk = ~i_core_clk;

	usbie_top DUT (.i_core_clk, .i_sys_rst, .i_awvalid, .o_awready,
		.i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid,
		.i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
		.i_rready, .o_rdata, .o_rresp, .i_rx_ack, .i_rx_nak, .i_tx_ack,
		.i_tx_nak, .i_setup_rcvd, .i_bus_events, .o_irq);

	usbie_sie_model sie (.i_core_clk, .o_rx_ack(i_rx_ack),
		.o_rx_nak(i_rx_nak), .o_tx_ack(i_tx_ack), .o_tx_nak(i_tx_nak),
		.o_setup_rcvd(i_setup_rcvd), .o_bus_events(i_bus_events));

	// Verdict, reached from the end and from any timeout
	task automatic finish_test();
		$display("Checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Implemented enable bits: 25 to 10 and 8 to 0
	function automatic logic [31:0] exp_mask(input logic [31:0] v);
		return v & 32'h03FF_FDFF;
	endfunction

	task automatic timeout();
		error_cnt++;
		$display("Error at %0t: bus answer missing", $time);
		finish_test();
	endtask

	// Write: bready raised early, each channel dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge i_core_clk);
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_awaddr <= a;
		i_wdata <= v;
		i_wstrb <= 4'hF;
		i_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_core_clk);
			if (o_awready && i_awvalid) i_awvalid <= 1'h0;
			if (o_wready && i_wvalid) i_wvalid <= 1'h0;
			if (o_bvalid) break;
		end
		if (n == 40) timeout();
		i_bready <= 1'h0;
		chk({30'h0, o_bresp}, 32'h0);
	endtask

	task automatic rd_reg(input logic [7:0] a);
		int n;
		@(posedge i_core_clk);
		i_arvalid <= 1'h1;
		i_araddr <= a;
		i_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge i_core_clk);
			if (o_arready && i_arvalid) i_arvalid <= 1'h0;
			if (o_rvalid) break;
		end
		if (n == 40) timeout();
		i_rready <= 1'h0;
		rd = o_rdata;
		rs = o_rresp;
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
		rd_reg(a);
		chk(rd, e);
		chk({30'h0, rs}, 32'h0);
	endtask

	// Fire one source, compare status, then clear it all
	task automatic ev(input int bit_no, input bit nak, input logic [31:0] e);
		sie.fire(bit_no, nak);
		repeat (2) @(posedge i_core_clk);
		expect_reg(`USBIE_STAT_OFS, e);
		wr(`USBIE_STAT_OFS, 32'hFFFF_FFFF);
	endtask

	initial begin
		seed = $urandom(4);
		repeat (16) @(posedge i_core_clk);
		i_sys_rst <= 1'h0;
		@(posedge i_core_clk);
		expect_reg(`USBIE_MASK_OFS, 32'h0);
		expect_reg(`USBIE_STAT_OFS, 32'h0);
		$display("Done: reset values");
		// Random masks, reserved bits must read back zero
		repeat (6) begin
			d = $urandom;
			wr(`USBIE_MASK_OFS, d);
			expect_reg(`USBIE_MASK_OFS, exp_mask(d));
		end
		wr(`USBIE_MASK_OFS, 32'hFFFF_FFFF);
		expect_reg(`USBIE_MASK_OFS, 32'h03FF_FDFF);
		rd_reg(8'h40);
		chk({30'h0, rs}, 32'h2);
		$display("Done: mask access");
		// Every source alone, then for bits 10 and up its other direction must stay quiet
		wr(`USBIE_MODE_OFS, 32'h1);
		for (b = 0; b < 26; b++) begin
			if (b == 9) continue;
			wr(`USBIE_MASK_OFS, 32'h1 << b);
			sie.fire(b, 1'h0);
			repeat (3) @(posedge i_core_clk);
			chk({31'h0, o_irq}, 32'h1);
			expect_reg(`USBIE_STAT_OFS, 32'h1 << b);
			wr(`USBIE_STAT_OFS, 32'h1 << b);
			repeat (2) @(posedge i_core_clk);
			chk({31'h0, o_irq}, 32'h0);
			if (b < 10) continue;
			sie.fire(b ^ 1, 1'h0);
			repeat (3) @(posedge i_core_clk);
			chk({31'h0, o_irq}, 32'h0);
			wr(`USBIE_STAT_OFS, 32'hFFFF_FFFF);
		end
		$display("Done: source map");
		// Global enable gates a pending source
		wr(`USBIE_MODE_OFS, 32'h0);
		wr(`USBIE_MASK_OFS, 32'h8);
		sie.fire(3, 1'h0);
		repeat (3) @(posedge i_core_clk);
		chk({31'h0, o_irq}, 32'h0);
		wr(`USBIE_MODE_OFS, 32'h1);
		repeat (3) @(posedge i_core_clk);
		chk({31'h0, o_irq}, 32'h1);
		wr(`USBIE_STAT_OFS, 32'hFFFF_FFFF);
		$display("Done: global enable");
		// Handshake policies per direction
		wr(`USBIE_CFG_OFS, 32'h04);
		ev(13, 1'h1, 32'h0);
		ev(12, 1'h1, 32'h1000);
		ev(11, 1'h1, 32'h800);
		wr(`USBIE_CFG_OFS, 32'h01);
		ev(10, 1'h1, 32'h0);
		ev(13, 1'h1, 32'h2000);
		wr(`USBIE_CFG_OFS, 32'h20);
		ev(14, 1'h1, 32'h4000);
		ev(14, 1'h1, 32'h0);
		ev(14, 1'h0, 32'h4000);
		ev(14, 1'h1, 32'h4000);
		// Two NAKs in a row after an ACK: only the first may count
		ev(14, 1'h0, 32'h4000);
		sie.nak_pair(14);
		repeat (2) @(posedge i_core_clk);
		expect_reg(`USBIE_STAT_OFS, 32'h4000);
		wr(`USBIE_STAT_OFS, 32'hFFFF_FFFF);
		ev(14, 1'h1, 32'h0);
		wr(`USBIE_CFG_OFS, 32'h30);
		ev(16, 1'h1, 32'h0);
		$display("Done: policies");
		// Bus reset leaves only its own enable
		wr(`USBIE_MASK_OFS, 32'hFFFF_FFFF);
		sie.fire(0, 1'h0);
		repeat (2) @(posedge i_core_clk);
		expect_reg(`USBIE_MASK_OFS, 32'h1);
		expect_reg(`USBIE_MODE_OFS, 32'h1);
		$display("Done: bus reset");
		finish_test();
	end
endmodule
`default_nettype wire
